// ### design/csct_counter_timer.v
/*
 * capacitive sense counter/timer: two 8-bit capture up-counters
 * (chainable), 6-bit relaxation counter, interval timer, sigma-delta
 * gating and modulation source; control bits are plain ports.
 * assumes the comparator, relaxation and slow oscillator inputs are
 * asynchronous and are sampled here; count clocks become enable pulses.
 */
`timescale 1ns/10ps
`include "csct_defines.vh"

// Contract
// - two 8-bit chainable counters plus 6-bit counter
// - disabled holds counters reset; trip captures
// - charge integration: comparator gates chained counter
// - continuous or one-shot; capture freezes counters except in continuous
// - interrupt from capture or 16-bit overflow
// - relax method one: low=count clock, high=oscillator
// - low terminal count captures high counter
// - relax method two: 6-bit terminal captures 16-bit
// - interval timer 6-bit down counter with preload
// - timer start from double-synchronized enable
// - each start loads preload, counts to zero
// - timer one-shot; re-enable restarts
// - timer clock slow oscillator or count clock
// - one-clock terminal pulse, low time preload periods
// - sigma-delta when enable and mode bit set
// - sigma-delta counts while comparator and start high
// - comparator low holds; resume only with start
// - sequence 8/12 bits, prescale to 256
// - dac setting 8 bits plus two range bits
// - 6-bit counter can interrupt for approximation delay
// - mode: stop, pulse width, period, continuous
// - chain bit joins counters to 16 bits
// - divider 1,2,4,8 from main oscillator
// - slow clock bit clocks high counter separately
module csct_counter_timer #(
    parameter CNT_W = `CSCT_CNT_W,
    parameter TMR_W = `CSCT_TMR_W
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire enable_i,
    input wire delta_sigma_mode_bit_i,
    input wire [1:0] mode_i,
    input wire chain_i,
    input wire [1:0] count_clock_divider_select_i,
    input wire high_counter_slow_clock_i,
    input wire relax_method_two_i,
    input wire irq_select_i,
    input wire invert_input_i,
    input wire timer_clock_select_i,
    input wire [TMR_W-1:0] interval_preload_i,
    input wire [TMR_W-1:0] relax_preload_i,
    input wire [7:0] current_dac_setting_i,
    input wire [1:0] current_range_bits_i,
    input wire prs_enable_i,
    input wire prs_long_i,
    input wire [3:0] prs_prescale_i,
    input wire comparator_zero_output_i,
    input wire relaxation_oscillator_i,
    input wire slow_oscillator_i,
    output reg [CNT_W-1:0] count_low_o,
    output reg [CNT_W-1:0] count_high_o,
    output reg overflow_o,
    output reg captured_o,
    output reg irq_o,
    output reg timer_tc_o,
    output reg delay_irq_o,
    output wire timer_start_o,
    output wire prs_out_o,
    output reg [7:0] current_dac_o,
    output reg [1:0] current_range_o,
    output wire sense_count_clock_o
);
    // input synchronisers: first stage read only by the second
    reg [1:0] cmp_s_r;
    reg [1:0] ro_s_r;
    reg [1:0] slow_s_r;
    reg [1:0] en_s_r;
    reg ro_d_r;
    reg slow_d_r;
    reg cmp_d_r;
    reg [2:0] div_r;
    reg [CNT_W-1:0] low_r;
    reg [CNT_W-1:0] high_r;
    reg [TMR_W-1:0] ro_cnt_r;
    reg frozen_r;
    reg armed_r;
    reg gate_r;
    reg sd_done_r;

    wire cmp_q = cmp_s_r[1];
    wire cmp_in = cmp_q ^ invert_input_i;
    wire ro_tick = ro_s_r[1] && !ro_d_r;
    wire slow_tick = slow_s_r[1] && !slow_d_r;
    wire rise = cmp_in && !cmp_d_r;
    wire fall = !cmp_in && cmp_d_r;
    wire sd_mode = enable_i && delta_sigma_mode_bit_i;
    reg cclk_tick;
    wire tmr_tick;
    wire tmr_tc;
    wire low_tick;
    wire high_tick;
    wire low_term;
    wire high_carry;
    wire ro_term;
    reg capture_ev;
    reg count_en;

    function [CNT_W-1:0] inc;
        input [CNT_W-1:0] v;
        begin
            inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            cmp_s_r <= 2'h0;
            ro_s_r <= 2'h0;
            slow_s_r <= 2'h0;
            en_s_r <= 2'h0;
            ro_d_r <= 1'b0;
            slow_d_r <= 1'b0;
            cmp_d_r <= 1'b0;
        end else begin
            cmp_s_r <= {cmp_s_r[0], comparator_zero_output_i};
            ro_s_r <= {ro_s_r[0], relaxation_oscillator_i};
            slow_s_r <= {slow_s_r[0], slow_oscillator_i};
            en_s_r <= {en_s_r[0], enable_i};
            ro_d_r <= ro_s_r[1];
            slow_d_r <= slow_s_r[1];
            cmp_d_r <= cmp_in;
        end
    end

    // count clock as an enable pulse: main oscillator / 1, 2, 4, 8
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            div_r <= 3'h0;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    always @* begin
        case (count_clock_divider_select_i)
            2'h0: cclk_tick = 1'b1;
            2'h1: cclk_tick = div_r[0];
            2'h2: cclk_tick = &div_r[1:0];
            2'h3: cclk_tick = &div_r;
            default: cclk_tick = 1'b1;
        endcase
    end
    assign sense_count_clock_o = cclk_tick;

    assign tmr_tick = timer_clock_select_i ? cclk_tick : slow_tick;

    csct_interval_timer #(
        .W(TMR_W)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .start_i(en_s_r[1]),
        .tick_i(tmr_tick),
        .preload_i(interval_preload_i),
        .running_o(timer_start_o),
        .tc_o(tmr_tc)
    );

    csct_prs_gen #(
        .PRE_W(`CSCT_PRE_W),
        .SEQ_W(`CSCT_SEQ_W)
    ) u_prs (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .enable_i(prs_enable_i),
        .long_seq_i(prs_long_i),
        .prescale_sel_i(prs_prescale_i),
        .prs_tick_o(),
        .prs_out_o(prs_out_o)
    );

    // low counter on the count clock; high on oscillator unless chained
    assign low_tick = cclk_tick;
    assign low_term = low_r == {CNT_W{1'b1}};
    assign high_carry = low_term && low_tick;
    assign high_tick = chain_i ? high_carry :
        (high_counter_slow_clock_i ? slow_tick : ro_tick);
    assign ro_term = ro_cnt_r == {TMR_W{1'b0}};

    // count gating per mode
    always @* begin
        count_en = 1'b0;
        capture_ev = 1'b0;
        if (sd_mode) begin
            count_en = cmp_q && timer_start_o && !sd_done_r;
            capture_ev = tmr_tc;
        end else if (relax_method_two_i) begin
            count_en = 1'b1;
            capture_ev = ro_term && ro_tick;
        end else if (!chain_i) begin
            count_en = 1'b1;
            capture_ev = low_term && low_tick;
        end else begin
            case (mode_i)
                `CSCT_MODE_STOP: begin
                    count_en = 1'b1;
                    capture_ev = irq_select_i ? (high_carry && (&high_r)) : rise;
                end
                `CSCT_MODE_PULSE: begin
                    count_en = gate_r;
                    capture_ev = gate_r && fall;
                end
                `CSCT_MODE_PERIOD: begin
                    count_en = gate_r;
                    capture_ev = gate_r && rise;
                end
                `CSCT_MODE_CONT: begin
                    count_en = 1'b1;
                    capture_ev = rise;
                end
                default: begin
                    count_en = 1'b0;
                    capture_ev = 1'b0;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i) begin
        if (srst_i || !enable_i) begin
            low_r <= {CNT_W{1'b0}};
            high_r <= {CNT_W{1'b0}};
            ro_cnt_r <= relax_preload_i;
            frozen_r <= 1'b0;
            armed_r <= 1'b0;
            gate_r <= 1'b0;
            sd_done_r <= 1'b0;
            count_low_o <= {CNT_W{1'b0}};
            count_high_o <= {CNT_W{1'b0}};
            overflow_o <= 1'b0;
            captured_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            irq_o <= 1'b0;
            if (sd_mode && timer_start_o == 1'b0 && armed_r) begin
                sd_done_r <= 1'b1;
            end
            if (timer_start_o) begin
                armed_r <= 1'b1;
            end
            // first edge after enable opens the gate; a frozen count never reopens it
            if (!gate_r && !frozen_r && rise) begin
                gate_r <= 1'b1;
            end else if (capture_ev && mode_i != `CSCT_MODE_CONT) begin
                gate_r <= 1'b0;
            end
            if (relax_method_two_i && ro_tick && !frozen_r) begin
                ro_cnt_r <= ro_term ? relax_preload_i : ro_cnt_r - {{(TMR_W-1){1'b0}}, 1'b1};
            end
            if (!frozen_r) begin
                if (count_en && low_tick) begin
                    low_r <= inc(low_r);
                end
                if (count_en && high_tick) begin
                    high_r <= inc(high_r);
                    if (chain_i && (&high_r)) begin
                        overflow_o <= 1'b1;
                    end
                end
                if (capture_ev) begin
                    count_low_o <= low_r;
                    count_high_o <= high_r;
                    captured_o <= 1'b1;
                    // sigma-delta and every mode but continuous freeze; continuous keeps running
                    frozen_r <= sd_mode || mode_i != `CSCT_MODE_CONT;
                end
                if (irq_select_i == `CSCT_IRQ_SEL_CAPTURE) begin
                    irq_o <= capture_ev;
                end else begin
                    irq_o <= chain_i && high_carry && count_en && (&high_r);
                end
            end
        end
    end

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            timer_tc_o <= 1'b0;
            delay_irq_o <= 1'b0;
            current_dac_o <= 8'h00;
            current_range_o <= 2'h0;
        end else begin
            timer_tc_o <= tmr_tc;
            delay_irq_o <= tmr_tc && !sd_mode;
            current_dac_o <= current_dac_setting_i;
            current_range_o <= current_range_bits_i;
        end
    end
endmodule // csct_counter_timer

// ### design/csct_defines.vh
/*
 * constants for the capacitive sense counter/timer block: mode codes,
 * interrupt select codes and widths.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CSCT_DEFINES_VH
`define CSCT_DEFINES_VH

`define CSCT_MODE_STOP 2'h0
`define CSCT_MODE_PULSE 2'h1
`define CSCT_MODE_PERIOD 2'h2
`define CSCT_MODE_CONT 2'h3

`define CSCT_CNT_W 8
`define CSCT_TMR_W 6
`define CSCT_SEQ_W 12
`define CSCT_PRE_W 8

`define CSCT_IRQ_SEL_CAPTURE 1'b0
`define CSCT_IRQ_SEL_OVERFLOW 1'b1

`endif

// ### design/csct_interval_timer.v
/*
 * 6-bit one-shot down-counting interval timer with one-cycle terminal
 * count pulse and a start level that stays high until terminal count.
 * assumes tick_i is a one-cycle enable on sys_clk_i and start_i is
 * already synchronised to sys_clk_i.
 */
`timescale 1ns/10ps
module csct_interval_timer #(
    parameter W = 6
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire start_i,
    input wire tick_i,
    input wire [W-1:0] preload_i,
    output wire running_o,
    output reg tc_o
);
    reg [W-1:0] count_r;
    reg running_r;
    reg done_r;

    assign running_o = running_r;

    always @(posedge sys_clk_i) begin
        if (srst_i || !start_i) begin
            count_r <= {W{1'b0}};
            running_r <= 1'b0;
            done_r <= 1'b0;
            tc_o <= 1'b0;
        end else begin
            tc_o <= 1'b0;
            if (!running_r && !done_r) begin
                count_r <= preload_i;
                running_r <= 1'b1;
            end else if (running_r && tick_i) begin
                if (count_r == {W{1'b0}}) begin
                    // one full cycle then stop until restarted
                    running_r <= 1'b0;
                    done_r <= 1'b1;
                    tc_o <= 1'b1;
                end else begin
                    count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // csct_interval_timer

// ### design/csct_prs_gen.v
/*
 * pseudo-random modulation source: power-of-two prescaler off the system
 * clock and an 8- or 12-bit maximal-length shift sequence.
 * assumes one system clock; prescale codes 0 to 8 select divide by 2^code, higher codes divide by 256.
 */
`timescale 1ns/10ps
module csct_prs_gen #(
    parameter PRE_W = 8,
    parameter SEQ_W = 12
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire enable_i,
    input wire long_seq_i,
    input wire [3:0] prescale_sel_i,
    output wire prs_tick_o,
    output reg prs_out_o
);
    reg [PRE_W-1:0] pre_r;
    reg [SEQ_W-1:0] lfsr_r;
    wire [PRE_W:0] pre_mask;
    wire fb;

    // divide by 1 (code 0) up to 256 (code 8)
    assign pre_mask = ({{PRE_W{1'b0}}, 1'b1} << prescale_sel_i) - {{PRE_W{1'b0}}, 1'b1};
    assign prs_tick_o = enable_i &&
        ((pre_r & pre_mask[PRE_W-1:0]) == pre_mask[PRE_W-1:0]);
    // taps: 8-bit x^8+x^6+x^5+x^4+1, 12-bit x^12+x^6+x^4+x+1
    assign fb = long_seq_i ?
        (lfsr_r[11] ^ lfsr_r[5] ^ lfsr_r[3] ^ lfsr_r[0]) :
        (lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]);

    always @(posedge sys_clk_i) begin
        if (srst_i || !enable_i) begin
            pre_r <= {PRE_W{1'b0}};
            lfsr_r <= {{(SEQ_W-1){1'b0}}, 1'b1};
            prs_out_o <= 1'b0;
        end else begin
            pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
            if (prs_tick_o) begin
                lfsr_r <= {lfsr_r[SEQ_W-2:0], fb};
                prs_out_o <= fb;
            end
        end
    end
endmodule // csct_prs_gen

// ### verif/csct_counter_timer_assertions.sv
/* port checker for the capacitive sense counter/timer.
   assumes it is bound to the top module by the bench. */
`timescale 1ns/10ps
module csct_counter_timer_assertions #(
    parameter CNT_W = 8
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire enable_i,
    input wire delta_sigma_mode_bit_i,
    input wire [1:0] mode_i,
    input wire irq_select_i,
    input wire [CNT_W-1:0] count_low_o,
    input wire [CNT_W-1:0] count_high_o,
    input wire overflow_o,
    input wire captured_o,
    input wire irq_o,
    input wire timer_tc_o,
    input wire delay_irq_o,
    input wire timer_start_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_tc_one_wide: assert property (timer_tc_o |=> !timer_tc_o)
        else $error("terminal pulse wider than one cycle");
    a_disable_clears: assert property (!enable_i ##1 !enable_i |->
        count_low_o == 0 && count_high_o == 0 && !captured_o && !overflow_o)
        else $error("disabled block kept a count or flag");
    a_start_lag: assert property ($rose(enable_i) |->
        !timer_start_o [*2] ##[1:2] timer_start_o)
        else $error("timer start not two stages behind enable");
    a_start_off: assert property (!enable_i [*4] |-> !timer_start_o)
        else $error("timer kept running while disabled");
    a_capture_held: assert property (captured_o && enable_i && mode_i != 2'h3 |=>
        captured_o && $stable(count_low_o) && $stable(count_high_o))
        else $error("captured count moved");
    a_overflow_sticky: assert property (overflow_o && enable_i |=> overflow_o)
        else $error("overflow flag dropped");
    a_irq_capture: assert property (irq_o && !irq_select_i && mode_i != 2'h3 |->
        captured_o)
        else $error("capture interrupt without capture");
    a_delay_source: assert property (delay_irq_o |-> !delta_sigma_mode_bit_i)
        else $error("delay interrupt in sigma-delta mode");
endmodule // csct_counter_timer_assertions

// ### verif/csct_front_end.sv
/* sensing front-end model: comparator, relaxation and slow oscillators.
   assumes the bench sets the comparator level and runs the oscillator. */
`timescale 1ns/10ps
module csct_front_end #(
    parameter real RO_HALF = 20.3,
    parameter real SLOW_HALF = 500.0
) (
    input wire cmp_req_i,
    input wire ro_run_i,
    output logic cmp_o,
    output logic ro_o,
    output logic slow_o
);
    initial begin
        cmp_o = 0;
        ro_o = 0;
        slow_o = 0;
    end
    // comparator settles off the clock grid, so sync stages are exercised
    always @(cmp_req_i) cmp_o <= #7 cmp_req_i;
    // parked while unused so no stray edge is counted
    always #(RO_HALF) if (ro_run_i) ro_o = ~ro_o;
    // far faster than a real slow oscillator to keep the run short
    always #(SLOW_HALF) slow_o = ~slow_o;
endmodule // csct_front_end

// ### verif/csct_counter_timer_bench.sv
/* bench for the counter/timer with the front-end model.
   assumes a 100 MHz clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module csct_counter_timer_bench;
    logic sys_clk_i = 0, srst_i = 1, enable_i = 0, delta_sigma_mode_bit_i = 0, chain_i = 0;
    logic high_counter_slow_clock_i = 0, relax_method_two_i = 0, irq_select_i = 0;
    logic invert_input_i = 0, timer_clock_select_i = 1, prs_enable_i = 1, prs_long_i = 0;
    logic [1:0] mode_i = 0, count_clock_divider_select_i = 0, current_range_bits_i = 2'h1;
    logic [5:0] interval_preload_i = 0, relax_preload_i = 8;
    logic [7:0] current_dac_setting_i = 8'h5a, count_low_o, count_high_o, current_dac_o;
    logic [3:0] prs_prescale_i = 0;
    logic [1:0] current_range_o;
    logic cmp_req = 0, ro_run = 0;
    logic comparator_zero_output_i, relaxation_oscillator_i, slow_oscillator_i;
    logic overflow_o, captured_o, irq_o, timer_tc_o, delay_irq_o, timer_start_o;
    logic prs_out_o, sense_count_clock_o;
    logic [15:0] v;
    int err_total = 0, checks_done = 0, k, n, m, t, d;

    always #5 sys_clk_i = ~sys_clk_i;
    csct_counter_timer i_dut (.*);
    csct_front_end i_fe (.cmp_req_i(cmp_req), .ro_run_i(ro_run),
        .cmp_o(comparator_zero_output_i), .ro_o(relaxation_oscillator_i),
        .slow_o(slow_oscillator_i));

    task cyc(input int c);
        repeat (c) @(posedge sys_clk_i);
        #1;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rng(input logic [31:0] seen, input int lo, input int hi);
        chk(seen >= lo && seen <= hi, 1);
    endtask
    task restart;
        enable_i = 0;
        cyc(5);
        enable_i = 1;
    endtask
    task wcap(input int b);
        for (k = 0; k < b && captured_o !== 1'b1; k++) cyc(1);
        v = {count_high_o, count_low_o};
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        // about 75k cycles of tests; a hang stops here
        #900_000;
        err_total++;
        end_of_test;
    end

    initial begin
        cyc(2);
        srst_i = 0;
        chk({count_high_o, count_low_o, captured_o, timer_start_o}, 0);
        cyc(1);
        chk({current_dac_o, current_range_o}, {8'h5a, 2'h1});
        // boundary preloads on the count clock, then one run on the slow clock
        for (m = 0; m < 4; m++) begin
            n = (m == 0) ? 1 : (m == 1) ? 5 : (m == 2) ? 63 : 3;
            timer_clock_select_i = (m != 3);
            interval_preload_i = n;
            restart;
            for (k = 0; k < 10 && timer_start_o !== 1'b1; k++) cyc(1);
            t = 0;
            d = 0;
            while (timer_tc_o !== 1'b1 && t < 2000) begin
                cyc(1);
                t++;
                d += delay_irq_o;
            end
            if (m < 3) chk(t, n + 2);
            else rng(t, 300, 510);
            n = 0;
            repeat (150) begin
                cyc(1);
                n += timer_tc_o;
                d += delay_irq_o;
            end
            chk(n, 0);
            chk(d, 1);
        end
        // sigma-delta interval below is counted in count clock periods
        timer_clock_select_i = 1;
        // stop on event, pulse width, period, then pulse width of the inverted input
        chain_i = 1;
        for (m = 0; m < 4; m++) begin
            mode_i = (m == 3) ? 2'h1 : m;
            invert_input_i = (m == 3);
            cmp_req = 0;
            restart;
            cyc(10);
            cmp_req = 1;
            cyc(60);
            cmp_req = 0;
            cyc(40);
            cmp_req = 1;
            wcap(40);
            chk(captured_o, 1);
            n = (m == 0) ? 10 : (m == 1) ? 60 : (m == 2) ? 100 : 40;
            rng(v, n - 2, n + 6);
            cyc(20);
            chk({count_high_o, count_low_o}, v);
        end
        invert_input_i = 0;
        delta_sigma_mode_bit_i = 1;
        mode_i = 0;
        interval_preload_i = 20;
        for (m = 1; m >= 0; m--) begin
            cmp_req = m;
            restart;
            wcap(100);
            if (m) rng(v, 17, 24);
            else chk(v, 0);
        end
        delta_sigma_mode_bit_i = 0;
        chain_i = 0;
        ro_run = 1;
        restart;
        wcap(400);
        rng(count_high_o, 61, 65);
        // high counter on the slow clock: 2 or 3 slow edges in 256 cycles
        high_counter_slow_clock_i = 1;
        restart;
        wcap(400);
        rng(count_high_o, 2, 3);
        high_counter_slow_clock_i = 0;
        chain_i = 1;
        relax_method_two_i = 1;
        restart;
        wcap(100);
        rng(v, 28, 40);
        relax_method_two_i = 0;
        ro_run = 0;
        for (m = 0; m < 4; m++) begin
            count_clock_divider_select_i = m;
            restart;
            t = 0;
            repeat (80) begin
                cyc(1);
                t += sense_count_clock_o;
            end
            rng(t, (80 >> m) - 1, (80 >> m) + 1);
        end
        // one full maximal sequence holds 2^(len-1) ones; long one last so
        // the short feedback never starts from a zero low byte
        for (m = 0; m < 3; m++) begin
            prs_long_i = (m == 2);
            prs_prescale_i = (m == 1);
            cyc(4);
            n = 0;
            repeat ((m == 2) ? 4095 : 255 << m) begin
                cyc(1);
                n += prs_out_o;
            end
            chk(n, (m == 2) ? 2048 : 128 << m);
        end
        count_clock_divider_select_i = 0;
        mode_i = 3;
        irq_select_i = 1;
        restart;
        t = 0;
        while (overflow_o !== 1'b1 && t < 70000) begin
            cyc(1);
            t++;
        end
        rng(t, 65530, 65545);
        chk(irq_o, 1);
        end_of_test;
    end
endmodule // csct_counter_timer_bench

bind csct_counter_timer csct_counter_timer_assertions #(.CNT_W(CNT_W)) i_chk (.*);
